// ---- brdt_fwd_model.sv ----
/*
 * brdt_fwd_model: stands in for the forwarding logic and the initiators
 * on both buses; it raises read-data-landed and initiator-returned pulses
 * and the retry-pending level.
 * Assumes one pclk shared with the register bank; tasks are entered just
 * after a rising edge and drive by non-blocking assignment.
 */
`timescale 1ns/100ps
module brdt_fwd_model (
   // clock
   input wire logic pclk,
   // towards the register bank
   output brdt_pkg::brdt_side_in_t sec_in,
   output brdt_pkg::brdt_side_in_t pri_in,
   output logic retry_pending
);
   initial begin
      sec_in = '0;
      pri_in = '0;
      retry_pending = 1'b0;
   end

   // one-cycle pulse: landed data when take is 0, initiator return if 1
   task automatic pulse(input bit pri, input bit take);
      if (pri) begin
         pri_in.start <= !take;
         pri_in.taken <= take;
      end else begin
         sec_in.start <= !take;
         sec_in.taken <= take;
      end
      @(posedge pclk);
      pri_in <= '0;
      sec_in <= '0;
   endtask

   task automatic retry(input bit on);
      retry_pending <= on;
   endtask
endmodule

// ---- brdt_pkg.sv ----
/*
 * brdt_pkg: register map, field positions, reset values, timing counts
 * and carrier types for the bridge retry and discard timer register bank.
 * Assumes a single PCI clock of 100 MHz driving both the register bus
 * and the timer logic.
 */
package brdt_pkg;

   // register byte offsets
   localparam logic [7:0] OFF_BRIDGE_CTRL = 8'h3C;
   localparam logic [7:0] OFF_RETRY_LIMIT = 8'h78;
   localparam logic [7:0] OFF_DISCARD_TMR = 8'h80;
   localparam logic [7:0] OFF_SLOT_CAP = 8'hB0;
   localparam logic [7:0] OFF_PM_CAP = 8'hDC;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'hF0;
   localparam logic [7:0] OFF_IRQ_MASK = 8'hF4;

   // field positions
   localparam int POS_COARSE_PRI = 24;
   localparam int POS_COARSE_SEC = 25;
   localparam int POS_FINE_SEC = 0;
   localparam int POS_FINE_PRI = 16;
   localparam int POS_SLOT_NUM = 16;
   localparam int POS_FIRST_CHASSIS = 21;
   localparam int POS_CHASSIS = 24;
   localparam int POS_CAP_NEXT = 8;

   // reset values and read-only contents
   localparam logic [31:0] RST_RETRY_LIMIT = 32'h0100_0000;
   localparam logic [15:0] RST_DISCARD_LOAD = 16'h8000;
   localparam logic [7:0] SLOT_CAP_ID = 8'h04;
   localparam logic [7:0] SLOT_CAP_NEXT_END = 8'h00;
   localparam logic [7:0] PM_CAP_ID = 8'h01;
   localparam logic [7:0] PM_CAP_NEXT = 8'h0B;

   // coarse discard loads in PCI clocks: 2^15 when the bit is 0, 2^10 if 1
   localparam logic [15:0] COARSE_LOAD_LONG = 16'h8000;
   localparam logic [15:0] COARSE_LOAD_SHORT = 16'h0400;

   // interrupt status bit positions
   localparam int IRQ_SEC_DISCARD = 0;
   localparam int IRQ_PRI_DISCARD = 1;
   localparam int IRQ_RETRY_TIMEOUT = 2;
   localparam int IRQ_WIDTH = 3;

   // side index for the two discard timers
   localparam int SIDE_SEC = 0;
   localparam int SIDE_PRI = 1;

   typedef enum logic {
      TMR_IDLE = 1'b0,
      TMR_RUN = 1'b1
   } brdt_tmr_st_t;

   // per-side events from the forwarding logic
   typedef struct packed {
      logic start;   // last data / first cache line completed to bridge
      logic taken;   // initiator came back for the read data
   } brdt_side_in_t;

endpackage

// ---- brdt_regs.sv ----
/*
 * brdt_regs: retry limit, primary and secondary discard timers, slot
 * identification and power management capability headers, behind an
 * APB slave with a sticky interrupt status and mask.
 * Assumes the forwarding logic runs on pclk and drives one-cycle start
 * and taken pulses per side plus a retry-pending level; the two mode
 * straps come from pins and are synchronised here.
 */
// The APB interface to the registers was chosen for this implementation.
// How it works
// RULE1: retry limit word, read/write, resets 0100_0000h.
// RULE2: default limit means 2^24 clocks before timeout.
// RULE3: secondary fine load, bits 15:0, resets 8000h.
// RULE4: control bit 25 loads secondary 2^10 or 2^15.
// RULE5: primary fine load, bits 31:16, resets 8000h.
// RULE6: control bit 24 loads primary 2^10 or 2^15.
// RULE7: last written of fine or coarse wins.
// RULE8: timer starts when read data lands.
// RULE9: expiry discards that transaction's buffered data.
// RULE10: slot slot_cap_id reads 04h.
// RULE11: slot next pointer reads 00h per straps.
// RULE12: slot number and first-in-chassis, read/write.
// RULE13: bits 23:22 of slot word read zero.
// RULE14: power management slot_cap_id reads 01h.
// RULE15: power management next pointer reads 0Bh.
// RULE16: writes to read-only fields change nothing.
// RULE17: timer counts down, zero before return discards.
`timescale 1ns/100ps
module brdt_regs #(
   parameter logic [7:0] SLOT_NEXT_NO_STRAP = 8'h00
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // mode strap pins
   input wire logic mode_strap_first,
   input wire logic mode_strap_second,
   // forwarding logic
   input wire brdt_pkg::brdt_side_in_t sec_in,
   input wire brdt_pkg::brdt_side_in_t pri_in,
   input wire logic retry_pending,
   output logic sec_discard,
   output logic pri_discard,
   output logic retry_timeout,
   // interrupt
   output logic irq
);

   logic pready_ff;
   logic pslverr_ff;
   logic [31:0] prdata_ff;
   logic [31:0] retry_limit_ff;
   logic [31:0] retry_cnt_ff;
   logic retry_to_ff;
   logic [1:0] coarse_ff;
   logic [15:0] load_ff [2];
   logic [15:0] timer_ff [2];
   logic [1:0] discard_ff;
   logic [4:0] slot_num_ff;
   logic first_chassis_ff;
   logic [7:0] chassis_ff;
   logic [2:0] irq_status_ff;
   logic [2:0] irq_mask_ff;
   logic irq_ff;
   logic [1:0] strap_meta_ff;
   logic [1:0] strap_sync_ff;
   logic [7:0] slot_next;
   logic setup;
   logic wr_en;
   logic [31:0] nxt_prdata;
   logic nxt_slverr;
   logic [1:0] side_start;
   logic [1:0] side_taken;
   logic [2:0] events;

   assign side_start = {pri_in.start, sec_in.start};
   assign side_taken = {pri_in.taken, sec_in.taken};

   // a write lands only at the edge where the access phase completes
   assign setup = psel & ~penable;
   assign wr_en = psel & penable & pready_ff & pwrite;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   function automatic logic [15:0] coarse_load(input logic bit_set);
      coarse_load = bit_set ? brdt_pkg::COARSE_LOAD_SHORT :
         brdt_pkg::COARSE_LOAD_LONG;
   endfunction

   // straps are pin levels: two flops before anything reads them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_meta_ff <= 2'h0;
         strap_sync_ff <= 2'h0;
      end else begin
         strap_meta_ff <= {mode_strap_second, mode_strap_first};
         strap_sync_ff <= strap_meta_ff;
      end
   end

   always_comb begin
      if (strap_sync_ff[0] | strap_sync_ff[1]) begin
         slot_next = brdt_pkg::SLOT_CAP_NEXT_END; // RULE11
      end else begin
         slot_next = SLOT_NEXT_NO_STRAP;
      end
   end

   // read mux: read-only words are constants, so writes cannot touch them
   always_comb begin
      nxt_prdata = 32'h0000_0000;
      nxt_slverr = 1'b0;
      case (paddr)
         brdt_pkg::OFF_BRIDGE_CTRL: begin
            nxt_prdata[brdt_pkg::POS_COARSE_SEC] = coarse_ff[0];
            nxt_prdata[brdt_pkg::POS_COARSE_PRI] = coarse_ff[1];
         end
         brdt_pkg::OFF_RETRY_LIMIT: begin
            nxt_prdata = retry_limit_ff;
         end
         brdt_pkg::OFF_DISCARD_TMR: begin
            nxt_prdata = {load_ff[brdt_pkg::SIDE_PRI],
               load_ff[brdt_pkg::SIDE_SEC]};
         end
         brdt_pkg::OFF_SLOT_CAP: begin
            // bits 23:22 stay zero
            nxt_prdata = {chassis_ff, 2'h0, first_chassis_ff, slot_num_ff,
               slot_next, brdt_pkg::SLOT_CAP_ID}; // RULE10 RULE13
         end
         brdt_pkg::OFF_PM_CAP: begin
            nxt_prdata = {16'h0000, brdt_pkg::PM_CAP_NEXT,
               brdt_pkg::PM_CAP_ID}; // RULE14 RULE15 RULE16
         end
         brdt_pkg::OFF_IRQ_STATUS: begin
            nxt_prdata = {29'h0, irq_status_ff};
         end
         brdt_pkg::OFF_IRQ_MASK: begin
            nxt_prdata = {29'h0, irq_mask_ff};
         end
         default: begin
            nxt_slverr = 1'b1;
         end
      endcase
   end

   // no wait state: the answer is registered during the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         pready_ff <= setup;
         pslverr_ff <= setup & nxt_slverr;
         if (setup && !pwrite) begin
            prdata_ff <= nxt_prdata;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         retry_limit_ff <= brdt_pkg::RST_RETRY_LIMIT;
      end else if (wr_en && hit(paddr, brdt_pkg::OFF_RETRY_LIMIT)) begin
         retry_limit_ff <= pwdata; // RULE1
      end
   end

   // fine field and coarse bit share one load register: last write wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         coarse_ff <= 2'h0;
         load_ff[0] <= brdt_pkg::RST_DISCARD_LOAD;
         load_ff[1] <= brdt_pkg::RST_DISCARD_LOAD;
      end else if (wr_en && hit(paddr, brdt_pkg::OFF_BRIDGE_CTRL)) begin
         coarse_ff <= {pwdata[brdt_pkg::POS_COARSE_PRI],
            pwdata[brdt_pkg::POS_COARSE_SEC]};
         load_ff[0] <= coarse_load(pwdata[brdt_pkg::POS_COARSE_SEC]); // RULE4
         load_ff[1] <= coarse_load(pwdata[brdt_pkg::POS_COARSE_PRI]); // RULE6
      end else if (wr_en && hit(paddr, brdt_pkg::OFF_DISCARD_TMR)) begin
         load_ff[0] <= pwdata[brdt_pkg::POS_FINE_SEC +: 16]; // RULE3 RULE7
         load_ff[1] <= pwdata[brdt_pkg::POS_FINE_PRI +: 16]; // RULE5 RULE7
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_num_ff <= 5'h00;
         first_chassis_ff <= 1'b0;
         chassis_ff <= 8'h00;
      end else if (wr_en && hit(paddr, brdt_pkg::OFF_SLOT_CAP)) begin
         slot_num_ff <= pwdata[brdt_pkg::POS_SLOT_NUM +: 5]; // RULE12
         first_chassis_ff <= pwdata[brdt_pkg::POS_FIRST_CHASSIS]; // RULE12
         chassis_ff <= pwdata[brdt_pkg::POS_CHASSIS +: 8];
      end
   end

   // discard timers; a new start while running reloads the count, but a same-cycle taken or expiry at zero wins
   brdt_pkg::brdt_tmr_st_t tstate_ff [2];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int s = 0; s < 2; s++) begin
            tstate_ff[s] <= brdt_pkg::TMR_IDLE;
            timer_ff[s] <= 16'h0000;
            discard_ff[s] <= 1'b0;
         end
      end else begin
         for (int s = 0; s < 2; s++) begin
            discard_ff[s] <= 1'b0;
            case (tstate_ff[s])
               brdt_pkg::TMR_IDLE: begin
                  if (side_start[s]) begin
                     tstate_ff[s] <= brdt_pkg::TMR_RUN; // RULE8
                     timer_ff[s] <= load_ff[s];
                  end
               end
               brdt_pkg::TMR_RUN: begin
                  if (side_taken[s]) begin
                     tstate_ff[s] <= brdt_pkg::TMR_IDLE;
                  end else if (timer_ff[s] == 16'h0000) begin
                     tstate_ff[s] <= brdt_pkg::TMR_IDLE;
                     discard_ff[s] <= 1'b1; // RULE9 RULE17
                  end else if (side_start[s]) begin
                     timer_ff[s] <= load_ff[s];
                  end else begin
                     timer_ff[s] <= timer_ff[s] - 16'h0001; // RULE17
                  end
               end
               default: begin
                  tstate_ff[s] <= brdt_pkg::TMR_IDLE;
               end
            endcase
         end
      end
   end

   // retry timeout: clocks spent retrying against the programmed limit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         retry_cnt_ff <= 32'h0000_0000;
         retry_to_ff <= 1'b0;
      end else begin
         retry_to_ff <= 1'b0;
         if (!retry_pending) begin
            retry_cnt_ff <= 32'h0000_0000;
         end else if (retry_cnt_ff + 32'h0000_0001 >= retry_limit_ff) begin
            retry_cnt_ff <= 32'h0000_0000;
            retry_to_ff <= 1'b1; // RULE2
         end else begin
            retry_cnt_ff <= retry_cnt_ff + 32'h0000_0001;
         end
      end
   end

   assign events = {retry_to_ff, discard_ff[1], discard_ff[0]};

   // sticky status, write one to clear; a same-cycle event wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_ff <= 3'h0;
      end else if (wr_en && hit(paddr, brdt_pkg::OFF_IRQ_STATUS)) begin
         irq_status_ff <= (irq_status_ff & ~pwdata[2:0]) | events;
      end else begin
         irq_status_ff <= irq_status_ff | events;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_ff <= 3'h0;
      end else if (wr_en && hit(paddr, brdt_pkg::OFF_IRQ_MASK)) begin
         irq_mask_ff <= pwdata[2:0];
      end
   end

   // irq lags status by one clock to keep the output flop-driven
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(irq_status_ff & irq_mask_ff);
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign sec_discard = discard_ff[0];
   assign pri_discard = discard_ff[1];
   assign retry_timeout = retry_to_ff;
   assign irq = irq_ff;

   a_retry_write: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
      wr_en && paddr == brdt_pkg::OFF_RETRY_LIMIT |=>
      retry_limit_ff == $past(pwdata))
      else $error("retry limit did not take written value");

   a_retry_expiry: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
      retry_to_ff |-> $past(retry_pending) &&
      ($past(retry_cnt_ff) + 32'h0000_0001 >= $past(retry_limit_ff)))
      else $error("retry timeout before limit reached");

   a_fine_sec_load: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
      wr_en && paddr == brdt_pkg::OFF_DISCARD_TMR |=>
      load_ff[0] == $past(pwdata[15:0]))
      else $error("secondary fine load wrong");

   a_fine_pri_load: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
      wr_en && paddr == brdt_pkg::OFF_DISCARD_TMR |=>
      load_ff[1] == $past(pwdata[31:16]))
      else $error("primary fine load wrong");

   a_coarse_sec: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
      wr_en && paddr == brdt_pkg::OFF_BRIDGE_CTRL |=>
      load_ff[0] == ($past(pwdata[25]) ? 16'h0400 : 16'h8000))
      else $error("secondary coarse load wrong");

   a_coarse_pri: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
      wr_en && paddr == brdt_pkg::OFF_BRIDGE_CTRL |=>
      load_ff[1] == ($past(pwdata[24]) ? 16'h0400 : 16'h8000))
      else $error("primary coarse load wrong");

   a_load_holds: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
      !(wr_en && (paddr == brdt_pkg::OFF_DISCARD_TMR ||
      paddr == brdt_pkg::OFF_BRIDGE_CTRL)) |=> $stable(load_ff[0]))
      else $error("load value changed without a write");

   a_timer_start: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
      tstate_ff[0] == brdt_pkg::TMR_IDLE && sec_in.start |=>
      tstate_ff[0] == brdt_pkg::TMR_RUN && timer_ff[0] == $past(load_ff[0]))
      else $error("secondary timer did not start");

   a_timer_discard: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
      tstate_ff[1] == brdt_pkg::TMR_RUN && timer_ff[1] == 16'h0000 &&
      !pri_in.taken |=> pri_discard ##1 !pri_discard)
      else $error("primary expiry did not discard once");

   a_timer_count: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
      tstate_ff[0] == brdt_pkg::TMR_RUN && timer_ff[0] != 16'h0000 &&
      !sec_in.taken && !sec_in.start |=> timer_ff[0] == $past(timer_ff[0]) -
      16'h0001 && !sec_discard)
      else $error("secondary timer did not count down");

   a_slot_word: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
      setup && !pwrite && paddr == brdt_pkg::OFF_SLOT_CAP |=>
      prdata[7:0] == 8'h04 && prdata[23:22] == 2'h0 &&
      prdata[20:16] == $past(slot_num_ff))
      else $error("slot capability word wrong");

   a_slot_next: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
      setup && !pwrite && paddr == brdt_pkg::OFF_SLOT_CAP &&
      (strap_sync_ff != 2'h0) |=> prdata[15:8] == 8'h00)
      else $error("slot next pointer not zero");

   a_pm_word: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
      setup && !pwrite && paddr == brdt_pkg::OFF_PM_CAP |=>
      prdata[15:0] == 16'h0B01 && pready) // RULE15
      else $error("power management header wrong");

   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      |(irq_status_ff & irq_mask_ff) |=> irq)
      else $error("interrupt not raised");

endmodule

// ---- brdt_tb.sv ----
/*
 * brdt_tb: self-checking bench for brdt_regs; register traffic over APB,
 * discard timers and retry limit exercised through the forwarding model.
 * Assumes the single-cycle APB answer and timer latency of the design.
 */
`timescale 1ns/100ps
module tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, irq;
   logic strap_a = 1'b1;
   logic strap_b = 1'b0;
   brdt_pkg::brdt_side_in_t sec_in, pri_in;
   logic retry_pending, sec_discard, pri_discard, retry_timeout;
   int fails = 0;
   int tests_run = 0;

   brdt_regs brdt_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .mode_strap_first(strap_a), .mode_strap_second(strap_b),
      .sec_in(sec_in), .pri_in(pri_in), .retry_pending(retry_pending),
      .sec_discard(sec_discard), .pri_discard(pri_discard),
      .retry_timeout(retry_timeout), .irq(irq));

   brdt_fwd_model brdt_fwd_model_inst (.pclk(pclk), .sec_in(sec_in),
      .pri_in(pri_in), .retry_pending(retry_pending));

   initial begin
      forever #5 pclk = ~pclk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      if (fails == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // one transfer; entered just after a rising edge, returns after one
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] r, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no wait count assumed: only the watchdog ends a hung access
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      chk({31'h0, e}, 32'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
         input logic [31:0] msk);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r & msk, exp);
      chk({31'h0, e}, 32'h0);
   endtask

   // start a timer and count edges until its discard pulse is seen
   task automatic tmr(input bit pri, input int load);
      int n;
      n = 0;
      brdt_fwd_model_inst.pulse(pri, 1'b0);
      do begin
         @(posedge pclk);
         n++;
      end while ((pri ? pri_discard : sec_discard) !== 1'b1 && n < 40000);
      chk(n, load + 2);
   endtask

   initial begin
      #500000;
      fails++;
      results();
   end

   initial begin
      logic [31:0] r;
      logic e;
      int n;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      rd(8'h78, 32'h0100_0000, 32'hFFFF_FFFF);
      rd(8'h80, 32'h8000_8000, 32'hFFFF_FFFF);
      rd(8'hB0, 32'h0000_0004, 32'hFFFF_FFFF);
      rd(8'hDC, 32'h0000_0B01, 32'h0000_FFFF);
      wr(8'hB0, 32'hFFFF_FFFF);
      rd(8'hB0, 32'hFF3F_0004, 32'hFFFF_FFFF);
      wr(8'hDC, 32'h0000_0000);
      rd(8'hDC, 32'h0000_0B01, 32'h0000_FFFF);
      strap_a <= 1'b0;
      strap_b <= 1'b1;
      repeat (4) @(posedge pclk);
      rd(8'hB0, 32'h0000_0000, 32'h0000_FF00);
      apb(1'b0, 8'h40, 32'h0, r, e);
      chk({e, r[30:0]}, 32'h8000_0000);
      wr(8'h78, 32'h0000_0004);
      rd(8'h78, 32'h0000_0004, 32'hFFFF_FFFF);
      // coarse bits: secondary short, primary long
      wr(8'h3C, 32'h0200_0000);
      rd(8'h80, 32'h8000_0400, 32'hFFFF_FFFF);
      tmr(1'b0, 1024);
      wr(8'h3C, 32'h0100_0000);
      rd(8'h3C, 32'h0100_0000, 32'hFFFF_FFFF);
      rd(8'h80, 32'h0400_8000, 32'hFFFF_FFFF);
      wr(8'h80, 32'h0005_0003);
      rd(8'h80, 32'h0005_0003, 32'hFFFF_FFFF);
      tmr(1'b0, 3);
      tmr(1'b1, 5);
      tmr(1'b1, 5);
      // initiator returns before expiry: nothing may be dropped
      brdt_fwd_model_inst.pulse(1'b1, 1'b0);
      @(posedge pclk);
      brdt_fwd_model_inst.pulse(1'b1, 1'b1);
      n = 0;
      repeat (12) begin
         @(posedge pclk);
         n += pri_discard;
      end
      chk(n, 0);
      wr(8'h3C, 32'h0000_0000);
      rd(8'h80, 32'h8000_8000, 32'hFFFF_FFFF);
      brdt_fwd_model_inst.retry(1'b1);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (retry_timeout !== 1'b1 && n < 20);
      // limit of 4 clocks, plus one for the registered pulse
      chk(n, 5);
      brdt_fwd_model_inst.retry(1'b0);
      @(posedge pclk);
      // all three events are latched but masked
      rd(8'hF0, 32'h0000_0007, 32'hFFFF_FFFF);
      chk({31'h0, irq}, 32'h0);
      wr(8'hF4, 32'h0000_0001);
      rd(8'hF4, 32'h0000_0001, 32'hFFFF_FFFF);
      chk({31'h0, irq}, 32'h1);
      wr(8'hF0, 32'h0000_0001);
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      rd(8'hF0, 32'h0000_0006, 32'hFFFF_FFFF);
      results();
   end
endmodule
